/* File: rtl/rxmtr_defs.svh */
// Register offsets, field positions and reset values for the receive controller
`ifndef RXMTR_DEFS_SVH
`define RXMTR_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define RXMTR_OFF_CTRL 12'h000
`define RXMTR_OFF_SYSCFG 12'h004
`define RXMTR_OFF_TOPER 12'h008
`define RXMTR_OFF_STATUS 12'h00C
`define RXMTR_OFF_MASK 12'h010
`define RXMTR_OFF_STATE 12'h014

// ----------------------------------------------------------------
// System configuration field positions
// ----------------------------------------------------------------
`define RXMTR_BIT_DBL_DIS 12
`define RXMTR_BIT_SLOW 22
`define RXMTR_BIT_RSV_HI 27
`define RXMTR_BIT_RSV_LO 23
`define RXMTR_BIT_WTOE 28
`define RXMTR_BIT_AUTR 29
`define RXMTR_BIT_AACK 30

// ----------------------------------------------------------------
// Control and status field positions
// ----------------------------------------------------------------
`define RXMTR_BIT_RXEN 0
`define RXMTR_BIT_RXDIS 1
`define RXMTR_ST_GOOD 0
`define RXMTR_ST_ERR 1
`define RXMTR_ST_TO 2
`define RXMTR_ST_W 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RXMTR_RST_SYSCFG 32'h00000000
`define RXMTR_RST_TOPER 16'h0000
`define RXMTR_RST_MASK 3'h0

`endif

/* File: rtl/rxmtr_pkg.sv */
// Types shared by the receive mode, timeout and re-enable controller
package rxmtr_pkg;
    typedef enum logic [1:0] {
        RXMTR_IDLE = 2'b00,
        RXMTR_HUNT = 2'b01,
        RXMTR_ACK = 2'b10
    } rxmtr_state_e;

    typedef enum logic [1:0] {
        RXMTR_RATE_850K = 2'b00,
        RXMTR_RATE_6M8 = 2'b01,
        RXMTR_RATE_110K = 2'b10
    } rxmtr_rate_e;
endpackage

/* File: rtl/rxmtr_countdown.sv */
// Frame-wait countdown timer with load, stop and expiry pulse
`timescale 1ns/1ps
module rxmtr_countdown #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Control
    input wire logic load,
    input wire logic stop,
    input wire logic [WIDTH-1:0] period,
    // Status
    output logic running,
    output logic expired
);
    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;
    logic run_q;
    logic run_d;
    logic exp_q;
    logic exp_d;

    // Load wins over stop so a fresh enable always restarts the wait
    always_comb begin
        cnt_d = cnt_q;
        run_d = run_q;
        exp_d = 1'b0;
        if (load) begin
            cnt_d = period;
            run_d = (period != '0);
            exp_d = (period == '0);
        end else if (stop) begin
            run_d = 1'b0;
        end else if (run_q) begin
            if (cnt_q == {{(WIDTH-1){1'b0}}, 1'b1}) begin
                run_d = 1'b0;
                exp_d = 1'b1;
            end
            cnt_d = cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // Register the countdown
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
            run_q <= 1'b0;
            exp_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            run_q <= run_d;
            exp_q <= exp_d;
        end
    end

    assign running = run_q;
    assign expired = exp_q;
endmodule

/* File: rtl/rxmtr_ctrl.sv */
// Receiver mode, frame-wait timeout and auto re-enable controller with APB registers
`timescale 1ns/1ps
`include "rxmtr_defs.svh"

// Summary of operation
// - Slow select set: long delimiter, 110k format.
// - Slow select clear: short delimiter, 6M8 if the header rate is 6M8, else 850k.
// - Timeout enabled: enable starts countdown, expiry stops.
// - Expiry sets the frame-wait timeout flag.
// - Auto re-enable off: any event returns idle.
// - Double buffer auto: restart except after timeout.
// - Single buffer auto: restart on failures only.
// - Double buffer auto with ack: restart after ack.
// - Disable bit zero double, one single.
module rxmtr_ctrl #(
    parameter int TO_WIDTH = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Receive front end events (same clock)
    input wire logic frame_good,
    input wire logic frame_fail,
    input wire logic header_error_flag,
    input wire logic [1:0] phr_rate,
    input wire logic ack_tx_done,
    // Receive front end control
    output logic rx_on,
    output logic long_sfd_hunt,
    output logic [1:0] rx_rate,
    output logic ack_tx_start,
    // Interrupt
    output logic irq
);
    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [31:0] cfg_q;
    logic [31:0] cfg_d;
    logic [TO_WIDTH-1:0] toper_q;
    logic [TO_WIDTH-1:0] toper_d;
    logic [`RXMTR_ST_W-1:0] stat_q;
    logic [`RXMTR_ST_W-1:0] stat_d;
    logic [`RXMTR_ST_W-1:0] mask_q;
    logic [`RXMTR_ST_W-1:0] mask_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic err_q;
    logic err_d;
    logic ph_q;
    logic ph_d;
    rxmtr_pkg::rxmtr_state_e st_q;
    rxmtr_pkg::rxmtr_state_e st_d;

    logic wr_en;
    logic rd_en;
    logic mapped;
    logic rx_en_req;
    logic rx_dis_req;
    logic slow_rate_rx_select;
    logic frame_wait_timeout_enable;
    logic rx_auto_reenable;
    logic auto_ack_enable;
    logic double_buffer_disable;
    logic dbl_mode;
    logic fail_ev;
    logic to_load;
    logic to_stop;
    logic to_running;
    logic frame_wait_timeout_flag;
    logic [`RXMTR_ST_W-1:0] ev_set;

    // Act only in the first access cycle; a second read-clear in the pready
    // cycle would wipe an event that landed during the first one
    assign wr_en = psel && penable && pwrite && !ph_q;
    assign rd_en = psel && penable && !pwrite && !ph_q;
    assign mapped = (paddr == `RXMTR_OFF_CTRL) || (paddr == `RXMTR_OFF_SYSCFG)
        || (paddr == `RXMTR_OFF_TOPER) || (paddr == `RXMTR_OFF_STATUS)
        || (paddr == `RXMTR_OFF_MASK) || (paddr == `RXMTR_OFF_STATE);
    assign rx_en_req = wr_en && (paddr == `RXMTR_OFF_CTRL) && pwdata[`RXMTR_BIT_RXEN];
    assign rx_dis_req = wr_en && (paddr == `RXMTR_OFF_CTRL) && pwdata[`RXMTR_BIT_RXDIS];

    // Configuration field views
    assign slow_rate_rx_select = cfg_q[`RXMTR_BIT_SLOW];
    assign frame_wait_timeout_enable = cfg_q[`RXMTR_BIT_WTOE];
    assign rx_auto_reenable = cfg_q[`RXMTR_BIT_AUTR];
    assign auto_ack_enable = cfg_q[`RXMTR_BIT_AACK];
    assign double_buffer_disable = cfg_q[`RXMTR_BIT_DBL_DIS];
    assign dbl_mode = !double_buffer_disable;
    assign fail_ev = frame_fail || header_error_flag;

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    // Reserved bits 27..23 are stored as written; software keeps them zero
    always_comb begin
        cfg_d = cfg_q;
        toper_d = toper_q;
        mask_d = mask_q;
        stat_d = stat_q;
        rdata_d = rdata_q;
        err_d = 1'b0;
        if (wr_en) begin
            case (paddr)
                `RXMTR_OFF_SYSCFG: begin
                    cfg_d = pwdata;
                end
                `RXMTR_OFF_TOPER: begin
                    toper_d = pwdata[TO_WIDTH-1:0];
                end
                `RXMTR_OFF_MASK: begin
                    mask_d = pwdata[`RXMTR_ST_W-1:0];
                end
                default: begin
                    err_d = !mapped;
                end
            endcase
        end
        if (rd_en) begin
            case (paddr)
                `RXMTR_OFF_SYSCFG: rdata_d = cfg_q;
                `RXMTR_OFF_TOPER: rdata_d = {{(32-TO_WIDTH){1'b0}}, toper_q};
                `RXMTR_OFF_STATUS: rdata_d = {{(32-`RXMTR_ST_W){1'b0}}, stat_q};
                `RXMTR_OFF_MASK: rdata_d = {{(32-`RXMTR_ST_W){1'b0}}, mask_q};
                `RXMTR_OFF_STATE: rdata_d = {29'h0, to_running, st_q};
                default: rdata_d = 32'h00000000;
            endcase
            err_d = !mapped;
            // Read clears status, but a new event in the same cycle survives
            if (paddr == `RXMTR_OFF_STATUS) begin
                stat_d = '0;
            end
        end
        stat_d = stat_d | ev_set;
    end

    // Register the bus-facing state
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_q <= `RXMTR_RST_SYSCFG;
            toper_q <= `RXMTR_RST_TOPER;
            mask_q <= `RXMTR_RST_MASK;
            stat_q <= '0;
            rdata_q <= 32'h00000000;
            err_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            toper_q <= toper_d;
            mask_q <= mask_d;
            stat_q <= stat_d;
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    // Read data is registered so prdata and pslverr lag by one edge; pready
    // is raised in the access phase only after the data is ready
    always_comb begin
        ph_d = psel && penable && !ph_q;
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ph_q <= 1'b0;
        end else begin
            ph_q <= ph_d;
        end
    end
    assign pready = ph_q;
    assign prdata = rdata_q;
    assign pslverr = err_q && ph_q;
    assign irq = |(stat_q & mask_q);

    // ----------------------------------------------------------------
    // Receiver sequencing
    // ----------------------------------------------------------------
    // Enable is acted on in the first access cycle only, so the countdown
    // is loaded at most once per enable write
    rxmtr_countdown #(
        .WIDTH(TO_WIDTH)
    ) u_wait (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .load(to_load),
        .stop(to_stop),
        .period(toper_q),
        .running(to_running),
        .expired(frame_wait_timeout_flag)
    );

    // Event decoding, then the next receiver state
    always_comb begin
        st_d = st_q;
        to_load = 1'b0;
        to_stop = 1'b0;
        ack_tx_start = 1'b0;
        ev_set = '0;
        case (st_q)
            rxmtr_pkg::RXMTR_IDLE: begin
                if (rx_en_req && !ph_q) begin
                    st_d = rxmtr_pkg::RXMTR_HUNT;
                    to_load = frame_wait_timeout_enable;
                end
            end
            rxmtr_pkg::RXMTR_HUNT: begin
                if (rx_dis_req) begin
                    st_d = rxmtr_pkg::RXMTR_IDLE;
                    to_stop = 1'b1;
                end else if (frame_wait_timeout_flag) begin
                    ev_set[`RXMTR_ST_TO] = 1'b1;
                    st_d = rxmtr_pkg::RXMTR_IDLE;
                end else if (frame_good) begin
                    ev_set[`RXMTR_ST_GOOD] = 1'b1;
                    to_stop = 1'b1;
                    if (rx_auto_reenable && dbl_mode && auto_ack_enable) begin
                        st_d = rxmtr_pkg::RXMTR_ACK;
                        ack_tx_start = 1'b1;
                    end else if (rx_auto_reenable && dbl_mode) begin
                        st_d = rxmtr_pkg::RXMTR_HUNT;
                        to_load = frame_wait_timeout_enable;
                    end else begin
                        st_d = rxmtr_pkg::RXMTR_IDLE;
                    end
                end else if (fail_ev) begin
                    ev_set[`RXMTR_ST_ERR] = 1'b1;
                    to_stop = 1'b1;
                    if (rx_auto_reenable) begin
                        st_d = rxmtr_pkg::RXMTR_HUNT;
                        to_load = frame_wait_timeout_enable;
                    end else begin
                        st_d = rxmtr_pkg::RXMTR_IDLE;
                    end
                end
            end
            rxmtr_pkg::RXMTR_ACK: begin
                if (ack_tx_done) begin
                    st_d = rxmtr_pkg::RXMTR_HUNT;
                    to_load = frame_wait_timeout_enable;
                end
            end
            default: begin
                st_d = rxmtr_pkg::RXMTR_IDLE;
            end
        endcase
    end

    // Register the receiver state
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= rxmtr_pkg::RXMTR_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // Front end steering
    assign rx_on = (st_q == rxmtr_pkg::RXMTR_HUNT);
    assign long_sfd_hunt = slow_rate_rx_select;
    assign rx_rate = slow_rate_rx_select ? rxmtr_pkg::RXMTR_RATE_110K
        : ((phr_rate == rxmtr_pkg::RXMTR_RATE_6M8) ? rxmtr_pkg::RXMTR_RATE_6M8
        : rxmtr_pkg::RXMTR_RATE_850K);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_good_dbl_noack;
        rx_on && frame_good && !frame_wait_timeout_flag && !rx_dis_req
            && rx_auto_reenable && dbl_mode && !auto_ack_enable;
    endsequence
    sequence s_ack_wait;
        st_q == rxmtr_pkg::RXMTR_ACK && !ack_tx_done;
    endsequence

    AST_SLOW_RATE: assert property (@(posedge sys_clk) disable iff (!rstn)
        slow_rate_rx_select |-> long_sfd_hunt && rx_rate == rxmtr_pkg::RXMTR_RATE_110K)
        else $error("slow rate mode not applied");
    AST_FAST_RATE: assert property (@(posedge sys_clk) disable iff (!rstn)
        !slow_rate_rx_select |-> !long_sfd_hunt && rx_rate != rxmtr_pkg::RXMTR_RATE_110K)
        else $error("short delimiter mode not applied");
    AST_TO_START: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st_q == rxmtr_pkg::RXMTR_IDLE && rx_en_req && !ph_q && frame_wait_timeout_enable
            && toper_q > 1) |=> to_running)
        else $error("countdown not started at enable");
    AST_TO_OFF: assert property (@(posedge sys_clk) disable iff (!rstn)
        (rx_on && frame_wait_timeout_flag && !rx_dis_req) |=> !rx_on)
        else $error("receiver kept on after timeout");
    AST_TO_FLAG: assert property (@(posedge sys_clk) disable iff (!rstn)
        (rx_on && frame_wait_timeout_flag && !rx_dis_req) |=> stat_q[`RXMTR_ST_TO])
        else $error("timeout flag not set");
    AST_NO_AUTO: assert property (@(posedge sys_clk) disable iff (!rstn)
        (rx_on && (frame_good || fail_ev) && !rx_auto_reenable) |=> !rx_on)
        else $error("receiver stayed on without auto re-enable");
    AST_DBL_RESTART: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_good_dbl_noack |=> rx_on)
        else $error("double buffer receiver not restarted");
    AST_SGL_GOOD: assert property (@(posedge sys_clk) disable iff (!rstn)
        (rx_on && frame_good && !frame_wait_timeout_flag && double_buffer_disable) |=> !rx_on)
        else $error("single buffer restarted after good frame");
    AST_ACK_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_ack_wait |=> !rx_on)
        else $error("receiver restarted before ack done");
    AST_ACK_DONE: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st_q == rxmtr_pkg::RXMTR_ACK && ack_tx_done) |=> rx_on)
        else $error("receiver not restarted after ack");
endmodule

/* File: bench/rxmtr_front_model.sv */
// Receive front end model: remote frame events and acknowledgement transmit completion
`timescale 1ns/1ps
module rxmtr_front_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Commands from the bench
    input wire logic send,
    input wire logic [1:0] kind,
    input wire logic ack_slow,
    // Device side
    input wire logic rx_on,
    input wire logic ack_tx_start,
    output logic frame_good,
    output logic frame_fail,
    output logic header_error_flag,
    output logic ack_tx_done
);
    logic [3:0] ack_cnt_q;

    // ----------------------------------------------------------------
    // Event pulses and acknowledgement timing
    // ----------------------------------------------------------------
    // Events only reach a hunting receiver; an idle one hears nothing
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            frame_good <= 1'b0;
            frame_fail <= 1'b0;
            header_error_flag <= 1'b0;
            ack_tx_done <= 1'b0;
            ack_cnt_q <= 4'h0;
        end else begin
            frame_good <= send && rx_on && kind == 2'h0;
            frame_fail <= send && rx_on && kind == 2'h1;
            header_error_flag <= send && rx_on && kind == 2'h2;
            ack_tx_done <= ack_cnt_q == 4'h1;
            // Slow answer keeps the device waiting long enough to be observed
            if (ack_tx_start) begin
                ack_cnt_q <= ack_slow ? 4'h8 : 4'h1;
            end else if (ack_cnt_q != 4'h0) begin
                ack_cnt_q <= ack_cnt_q - 4'h1;
            end
        end
    end
endmodule

/* File: bench/rxmtr_ctrl_test.sv */
// Self-checking testbench for the receive mode, timeout and re-enable controller
`timescale 1ns/1ps
`include "rxmtr_defs.svh"
module rxmtr_ctrl_test;
    typedef struct packed {
        logic [31:0] cfg;
        logic [1:0] kind;
        logic [1:0] phr;
        logic [1:0] rate;
        logic on;
        logic [2:0] st;
    } rxmtr_row_s;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, frame_good, frame_fail, header_error_flag, ack_tx_done;
    logic [1:0] phr_rate = 2'h0;
    logic [1:0] kind = 2'h0;
    logic [1:0] rx_rate;
    logic rx_on, long_sfd_hunt, ack_tx_start, irq;
    logic send = 1'b0, ack_slow = 1'b0;
    int err_total = 0, samples_checked = 0, cyc = 0;
    rxmtr_row_s rows [7];

    // ----------------------------------------------------------------
    // Clock, design and far side
    // ----------------------------------------------------------------
    always #10 sys_clk = ~sys_clk;

    rxmtr_ctrl #(.TO_WIDTH(16)) dut (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .frame_good(frame_good), .frame_fail(frame_fail),
        .header_error_flag(header_error_flag), .phr_rate(phr_rate), .ack_tx_done(ack_tx_done),
        .rx_on(rx_on), .long_sfd_hunt(long_sfd_hunt), .rx_rate(rx_rate),
        .ack_tx_start(ack_tx_start), .irq(irq));

    rxmtr_front_model far (.sys_clk(sys_clk), .rstn(rstn), .send(send), .kind(kind),
        .ack_slow(ack_slow), .rx_on(rx_on), .ack_tx_start(ack_tx_start),
        .frame_good(frame_good), .frame_fail(frame_fail),
        .header_error_flag(header_error_flag), .ack_tx_done(ack_tx_done));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; waits for pready however long the slave takes
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pulse(input logic [1:0] k);
        @(posedge sys_clk);
        kind <= k;
        send <= 1'b1;
        @(posedge sys_clk);
        send <= 1'b0;
    endtask

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            print_verdict();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        // Config, event kind, header rate, expected rate, receiver on, status
        rows[0] = '{32'h0000_0000, 2'h0, 2'h0, rxmtr_pkg::RXMTR_RATE_850K, 1'b0, 3'h1};
        rows[1] = '{32'h0000_0000, 2'h2, 2'h1, rxmtr_pkg::RXMTR_RATE_6M8, 1'b0, 3'h2};
        rows[2] = '{32'h2040_0000, 2'h0, 2'h1, rxmtr_pkg::RXMTR_RATE_110K, 1'b1, 3'h1};
        rows[3] = '{32'h2000_0000, 2'h1, 2'h0, rxmtr_pkg::RXMTR_RATE_850K, 1'b1, 3'h2};
        rows[4] = '{32'h2000_1000, 2'h0, 2'h1, rxmtr_pkg::RXMTR_RATE_6M8, 1'b0, 3'h1};
        rows[5] = '{32'h2000_1000, 2'h2, 2'h0, rxmtr_pkg::RXMTR_RATE_850K, 1'b1, 3'h2};
        rows[6] = '{32'h2000_1000, 2'h1, 2'h0, rxmtr_pkg::RXMTR_RATE_850K, 1'b1, 3'h2};
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        chk({26'h0, rx_on, long_sfd_hunt, rx_rate, ack_tx_start, irq}, 32'h0);
        apb(1'b0, `RXMTR_OFF_SYSCFG, 32'h0);
        chk(rd, `RXMTR_RST_SYSCFG);
        apb(1'b0, `RXMTR_OFF_MASK, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `RXMTR_OFF_SYSCFG, 32'h7040_1000);
        apb(1'b0, `RXMTR_OFF_SYSCFG, 32'h0);
        chk(rd, 32'h7040_1000);
        $display("test reset and config done");
        // Events with auto re-enable off, double buffer auto and single buffer auto (no ack); mask is zero, so irq must stay low
        for (int i = 0; i < 7; i++) begin
            phr_rate <= rows[i].phr;
            apb(1'b1, `RXMTR_OFF_SYSCFG, rows[i].cfg);
            apb(1'b1, `RXMTR_OFF_CTRL, 32'h1);
            pulse(rows[i].kind);
            repeat (4) @(posedge sys_clk);
            chk({27'h0, rx_rate, long_sfd_hunt, rx_on, irq},
                {27'h0, rows[i].rate, rows[i].cfg[22], rows[i].on, 1'b0});
            apb(1'b0, `RXMTR_OFF_STATUS, 32'h0);
            chk(rd, {29'h0, rows[i].st});
            apb(1'b1, `RXMTR_OFF_CTRL, 32'h2);
        end
        $display("test event table done");
        // Frame-wait expiry with auto re-enable set must not restart
        apb(1'b1, `RXMTR_OFF_TOPER, 32'h5);
        apb(1'b1, `RXMTR_OFF_MASK, 32'h4);
        apb(1'b1, `RXMTR_OFF_SYSCFG, 32'h3000_0000);
        apb(1'b1, `RXMTR_OFF_CTRL, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, rx_on}, 32'h1);
        repeat (6) @(posedge sys_clk);
        chk({30'h0, rx_on, irq}, 32'h1);
        apb(1'b0, `RXMTR_OFF_STATE, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `RXMTR_OFF_STATUS, 32'h0);
        chk(rd, 32'h4);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        $display("test timeout done");
        // Double buffer with acknowledgement: restart waits for the slow ack
        ack_slow <= 1'b1;
        apb(1'b1, `RXMTR_OFF_SYSCFG, 32'h6000_0000);
        apb(1'b1, `RXMTR_OFF_CTRL, 32'h1);
        pulse(2'h0);
        apb(1'b0, `RXMTR_OFF_STATE, 32'h0);
        chk(rd, 32'h2);
        chk({31'h0, rx_on}, 32'h0);
        repeat (10) @(posedge sys_clk);
        chk({31'h0, rx_on}, 32'h1);
        $display("test ack restart done");
        // Event during the read that clears status must survive the read
        fork
            pulse(2'h0);
            apb(1'b0, `RXMTR_OFF_STATUS, 32'h0);
        join
        chk(rd, 32'h1);
        apb(1'b0, `RXMTR_OFF_STATUS, 32'h0);
        chk(rd, 32'h1);
        $display("test status race done");
        // Unmapped place: error response and zero data
        apb(1'b0, 12'hFFC, 32'h0);
        chk({er, rd[30:0]}, 32'h8000_0000);
        $display("test unmapped done");
        print_verdict();
    end
endmodule
